// ### include/mbo_pkg.sv
// Summary of operation
// - by default a rising edge on input one sends up to all drives
// - by default a falling edge on input one sends stop to all drives
// - by default a rising edge on input two sends down to all drives
// - by default a falling edge on input two sends stop to all drives
// - the command for each edge of each input is reconfigurable
// - once a manual input is used, host movement commands are blocked
// - host acceptance resumes only on a rising edge of the re-enable input or on reset
// - up to 16 drives, each reachable by its own address
// - host up, down, stop, position and slat angle become bus telegrams
// - drive replies with position, errors and service data go to the host
package mbo_pkg;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;
    localparam logic [ADDR_W-1:0] BCAST_ADDR = 4'h0;
    typedef enum logic [2:0] {
        MBO_CMD_STOP,
        MBO_CMD_UP,
        MBO_CMD_DOWN,
        MBO_CMD_POS,
        MBO_CMD_ANGLE,
        MBO_CMD_NONE
    } mbo_cmd_t;
    // default edge assignments of the two manual inputs
    localparam logic [2:0] DEF_ONE_RISE = 3'h1;
    localparam logic [2:0] DEF_ONE_FALL = 3'h0;
    localparam logic [2:0] DEF_TWO_RISE = 3'h2;
    localparam logic [2:0] DEF_TWO_FALL = 3'h0;
    // one request toward the motor bus, or from the host
    typedef struct packed {
        logic valid;
        logic broadcast;
        logic [ADDR_W-1:0] addr;
        logic [2:0] cmd;
        logic [DATA_W-1:0] arg;
    } mbo_tel_t;
    // one reply from a drive
    typedef struct packed {
        logic valid;
        logic [ADDR_W-1:0] addr;
        logic [1:0] kind;
        logic [DATA_W-1:0] data;
    } mbo_reply_t;
    // per-edge command table
    typedef struct packed {
        logic [2:0] one_rise;
        logic [2:0] one_fall;
        logic [2:0] two_rise;
        logic [2:0] two_fall;
    } mbo_map_t;
endpackage

// ### hw/mbo_edge.sv
`timescale 1ns/1ps
// two-stage synchroniser plus edge detector for one pin
module mbo_edge (
    input wire logic mclk,
    input wire logic reset,
    input wire logic pin,
    output logic rise,
    output logic fall
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic rise;
        logic fall;
    } mbo_edge_st_t;
    mbo_edge_st_t st;
    mbo_edge_st_t next_st;

    // edges are seen only between s2 and s3, never on the first stage
    always_comb begin
        next_st = st;
        next_st.s1 = pin;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        next_st.rise = st.s2 & ~st.s3;
        next_st.fall = ~st.s2 & st.s3;
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign rise = st.rise;
    assign fall = st.fall;
endmodule

// ### hw/mbo_override.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// command interpreter: host requests and manual inputs to motor-bus telegrams
module mbo_override #(
    parameter int DRIVES = 16
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic manual_input_one,
    input wire logic manual_input_two,
    input wire logic host_command_reenable,
    input wire logic map_load,
    input wire mbo_pkg::mbo_map_t map_in,
    input wire mbo_pkg::mbo_tel_t host_req,
    output logic host_ready,
    output mbo_pkg::mbo_tel_t bus_tel,
    input wire logic bus_ready,
    input wire mbo_pkg::mbo_reply_t drive_reply,
    output mbo_pkg::mbo_reply_t host_reply,
    output logic manual_lock,
    output logic [DRIVES-1:0] drive_seen
);
    ////////////////////////////////////////////////////////////////////////////
    // whole state of the block in one register; tel, reply, lock, seen and
    // host_ready are the visible outputs, pend_man is the one-deep manual command slot
    typedef struct packed {
        mbo_pkg::mbo_map_t map;
        mbo_pkg::mbo_tel_t tel;
        mbo_pkg::mbo_reply_t reply;
        mbo_pkg::mbo_tel_t pend_man;
        logic lock;
        logic re_s1;
        logic re_s2;
        logic re_s3;
        logic host_ready;
        logic [DRIVES-1:0] seen;
    } mbo_st_t;
    mbo_st_t st;
    mbo_st_t next_st;
    logic one_rise;
    logic one_fall;
    logic two_rise;
    logic two_fall;
    logic any_edge;
    logic re_rise;
    logic host_take;

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    // true when any of the four manual edge pulses is up; the lock, the
    // pending slot and the host refusal must all agree on this one condition
    function automatic logic edge_seen(
        input logic a,
        input logic b,
        input logic c,
        input logic d
    );
        return a | b | c | d;
    endfunction

    // command of the edge that fired; one pin shows at most one edge a cycle,
    // so the fixed order only decides when both pins move in the same cycle
    function automatic logic [2:0] edge_cmd(
        input mbo_pkg::mbo_map_t m,
        input logic r1,
        input logic f1,
        input logic r2
    );
        logic [2:0] c;
        c = m.two_fall;
        if (r1) begin
            c = m.one_rise;
        end else if (f1) begin
            c = m.one_fall;
        end else if (r2) begin
            c = m.two_rise;
        end
        return c;
    endfunction

    // host codes above slat angle have no telegram; they go out as stop so
    // that a bad request can never leave a drive moving
    function automatic logic [2:0] host_cmd(input logic [2:0] cmd);
        logic [2:0] c;
        c = cmd;
        if (cmd > 3'(mbo_pkg::MBO_CMD_ANGLE)) begin
            c = 3'(mbo_pkg::MBO_CMD_STOP);
        end
        return c;
    endfunction

    // a reply address beyond the drive count is not marked; with fewer than
    // 16 drives this keeps the index inside the seen vector
    function automatic logic addr_in_range(input logic [mbo_pkg::ADDR_W-1:0] a);
        return 32'(a) < DRIVES;
    endfunction

    // host may offer a request only when nothing at all is in flight, which
    // keeps one request at a time and the answer order obvious
    function automatic logic slot_idle(
        input logic locked,
        input logic tel_busy,
        input logic man_busy
    );
        return !locked && !tel_busy && !man_busy;
    endfunction

    // builds a broadcast telegram for a manual edge
    function automatic mbo_pkg::mbo_tel_t man_tel(input logic [2:0] cmd);
        mbo_pkg::mbo_tel_t t;
        t = '0;
        t.valid = (cmd != 3'(mbo_pkg::MBO_CMD_NONE));
        t.broadcast = 1'b1;
        t.addr = mbo_pkg::BCAST_ADDR;
        t.cmd = cmd;
        return t;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    mbo_edge u_one (
        .mclk(mclk),
        .reset(reset),
        .pin(manual_input_one),
        .rise(one_rise),
        .fall(one_fall)
    );
    mbo_edge u_two (
        .mclk(mclk),
        .reset(reset),
        .pin(manual_input_two),
        .rise(two_rise),
        .fall(two_fall)
    );

    ////////////////////////////////////////////////////////////////////////////
    // decoded events of this cycle, shared by the next-state logic below
    assign any_edge = edge_seen(one_rise, one_fall, two_rise, two_fall);
    // re-enable acts on its synchronised rising edge only, never on its level
    assign re_rise = st.re_s2 & ~st.re_s3;
    // a host request is taken only when ready was shown, no lock stands and
    // no manual edge arrives in the same cycle, so a host command can never
    // slip past a manual edge that is already on its way
    assign host_take = host_req.valid & st.host_ready & ~st.lock & ~any_edge;

    ////////////////////////////////////////////////////////////////////////////
    // next state: manual commands win over host ones on the bus
    always_comb begin
        next_st = st;
        next_st.re_s1 = host_command_reenable;
        next_st.re_s2 = st.re_s1;
        next_st.re_s3 = st.re_s2;
        // table loads at any time; defaults are only the reset contents
        if (map_load) begin
            next_st.map = map_in;
        end
        // a sent telegram leaves the output once the bus takes it
        if (st.tel.valid && bus_ready) begin
            next_st.tel.valid = 1'b0;
        end
        // latest manual edge is held until the bus can take it; a newer edge
        // overwrites an older one still waiting, since only the last command
        // a user gave should reach the drives
        if (any_edge) begin
            next_st.pend_man = man_tel(edge_cmd(st.map, one_rise, one_fall, two_rise));
        end
        // a rising re-enable edge clears the lock, but a manual edge
        // in the same cycle sets it again; the set is written last so it wins
        if (re_rise) begin
            next_st.lock = 1'b0;
        end
        // any edge locks out the host, even one mapped to no command, because
        // the user has taken the drives over either way
        if (any_edge) begin
            next_st.lock = 1'b1;
        end
        // bus slot free: manual first, then an unblocked host request
        if (!next_st.tel.valid) begin
            if (st.pend_man.valid) begin
                next_st.tel = st.pend_man;
                // keep the slot if a newer edge has just been stored in it
                if (!any_edge) begin
                    next_st.pend_man.valid = 1'b0;
                end
            end else if (host_take) begin
                // host address goes out as given, one of up to 16 drives
                next_st.tel = host_req;
                next_st.tel.cmd = host_cmd(host_req.cmd);
            end
        end
        // host is told to hold off while locked or while the slot is busy
        next_st.host_ready = slot_idle(next_st.lock, next_st.tel.valid,
            next_st.pend_man.valid);
        // replies pass straight to the host, one cycle later
        next_st.reply = drive_reply;
        // seen bits are sticky until reset, so the host can poll at leisure;
        // an address past the drive count is ignored rather than wrapped
        if (drive_reply.valid && addr_in_range(drive_reply.addr)) begin
            next_st.seen[drive_reply.addr] = 1'b1;
        end
    end

    // one register stage for the whole block
    always_ff @(posedge mclk) begin
        if (reset) begin
            st <= '0;
            st.map.one_rise <= mbo_pkg::DEF_ONE_RISE;
            st.map.one_fall <= mbo_pkg::DEF_ONE_FALL;
            st.map.two_rise <= mbo_pkg::DEF_TWO_RISE;
            st.map.two_fall <= mbo_pkg::DEF_TWO_FALL;
        end else begin
            st <= next_st;
        end
    end

    assign host_ready = st.host_ready;
    assign bus_tel = st.tel;
    assign host_reply = st.reply;
    assign manual_lock = st.lock;
    assign drive_seen = st.seen;
endmodule

// ### dv/mbo_chk.sv
`timescale 1ns/1ps
////////////////////////////////////////
module mbo_chk #(
    parameter int DRIVES = 16
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic manual_input_one,
    input wire logic host_command_reenable,
    input wire logic host_ready,
    input wire mbo_pkg::mbo_tel_t bus_tel,
    input wire logic bus_ready,
    input wire mbo_pkg::mbo_reply_t drive_reply,
    input wire mbo_pkg::mbo_reply_t host_reply,
    input wire logic manual_lock,
    input wire logic [DRIVES-1:0] drive_seen
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    // a new telegram and a rising edge on input one
    sequence tel_start; $rose(bus_tel.valid); endsequence
    sequence pin_rise; $rose(manual_input_one); endsequence
    tel_hold_a: assert property (bus_tel.valid && !bus_ready |=> $stable(bus_tel))
        else $error("telegram changed before ready");
    ready_low_a: assert property (bus_tel.valid |-> !host_ready)
        else $error("host ready while telegram pending");
    reply_copy_a: assert property (drive_reply.valid |=> host_reply == $past(drive_reply))
        else $error("reply not passed to host");
    seen_sticky_a: assert property (drive_reply.valid |=> drive_seen[$past(drive_reply.addr)])
        else $error("replying drive not marked");
    lock_set_a: assert property (pin_rise |-> ##[1:6] manual_lock)
        else $error("manual edge did not lock host");
    lock_host_a: assert property (tel_start |-> bus_tel.broadcast || !manual_lock)
        else $error("host telegram while locked");
    host_block_a: assert property (manual_lock |-> !host_ready)
        else $error("host ready while locked");
    lock_clear_a: assert property ($fell(manual_lock) |->
        $past(host_command_reenable, 3) && !$past(host_command_reenable, 4))
        else $error("lock cleared without reenable edge");
    bcast_addr_a: assert property (tel_start |->
        !bus_tel.broadcast || bus_tel.addr == mbo_pkg::BCAST_ADDR)
        else $error("broadcast with wrong address");
endmodule
bind mbo_override mbo_chk #(.DRIVES(DRIVES)) i_mbo_chk (.mclk, .reset, .manual_input_one,
    .host_command_reenable, .host_ready, .bus_tel, .bus_ready, .drive_reply, .host_reply,
    .manual_lock, .drive_seen);

// ### dv/mbo_drive_model.sv
`timescale 1ns/1ps
////////////////////////////////////////
module mbo_drive_model (
    input wire logic mclk,
    input wire logic slow,
    input wire mbo_pkg::mbo_tel_t bus_tel,
    output logic bus_ready,
    output mbo_pkg::mbo_reply_t drive_reply
);
    int wait_n = 0;
    initial begin
        bus_ready = 1'b0;
        drive_reply = '0;
    end
    // accept after a short or long wait; idle data keeps moving so stale values never match
    always @(posedge mclk) begin
        drive_reply.data <= ~drive_reply.data;
        drive_reply.valid <= 1'b0;
        bus_ready <= 1'b0;
        if (bus_tel.valid && !bus_ready) begin
            wait_n <= wait_n + 1;
            if (wait_n >= (slow ? 4 : 0)) begin
                bus_ready <= 1'b1;
                wait_n <= 0;
                if (!bus_tel.broadcast) drive_reply <= {1'b1, bus_tel.addr, 2'h1, bus_tel.arg};
            end
        end
    end
endmodule

// ### dv/tb_top.sv
`timescale 1ns/1ps
////////////////////////////////////////
module tb_top;
    typedef struct packed {logic [3:0] addr; logic [2:0] cmd; logic [2:0] exp;} mbo_row_t;
    logic mclk = 0, reset = 1, manual_input_one = 0, manual_input_two = 0, map_load = 0;
    logic host_command_reenable = 0, slow = 0, host_ready, bus_ready, manual_lock;
    logic [15:0] drive_seen, seen = 0;
    mbo_pkg::mbo_map_t map_in = '0;
    mbo_pkg::mbo_tel_t host_req = '0, bus_tel, tel;
    mbo_pkg::mbo_reply_t drive_reply, host_reply, rep;
    int err_count = 0, comparisons = 0;
    // code 6 is out of range and must turn into stop
    mbo_row_t rows [6] = '{'{4'h3, 3'h1, 3'h1}, '{4'hF, 3'h2, 3'h2}, '{4'h1, 3'h0, 3'h0},
        '{4'h7, 3'h3, 3'h3}, '{4'h9, 3'h4, 3'h4}, '{4'h2, 3'h6, 3'h0}};
    initial forever #20 mclk = ~mclk;
    mbo_override i_mbo_override (.mclk, .reset, .manual_input_one, .manual_input_two,
        .host_command_reenable, .map_load, .map_in, .host_req, .host_ready, .bus_tel,
        .bus_ready, .drive_reply, .host_reply, .manual_lock, .drive_seen);
    mbo_drive_model i_mbo_drive_model (.mclk, .slow, .bus_tel, .bus_ready, .drive_reply);
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
        comparisons++;
        if (exp !== got) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // a wait that ran out ends the run with a verdict
    task automatic bound(int n);
        if (n >= 60) begin
            err_count++;
            complete_run();
        end
    endtask
    // take the next telegram, then wait until the drive has accepted it
    task automatic get_tel;
        int n;
        for (n = 0; n < 60 && bus_tel.valid !== 1'b1; n++) @(negedge mclk);
        bound(n);
        tel = bus_tel;
        for (n = 0; n < 60 && bus_tel.valid !== 1'b0; n++) @(negedge mclk);
        bound(n);
        // the reply to an accepted telegram stands in this very cycle
        rep = host_reply;
    endtask
    task automatic quiet;
        repeat (12) begin
            @(negedge mclk);
            chk("no telegram", 0, bus_tel.valid);
        end
    endtask
    // request held unchanged until the edge that takes it
    task automatic send(mbo_row_t r, bit locked);
        int n;
        host_req = '{1'b1, 1'b0, r.addr, r.cmd, {12'h0, r.addr}};
        if (locked) begin
            quiet();
            host_command_reenable = 1'b1;
        end
        for (n = 0; n < 60 && !(host_ready === 1'b1 && manual_lock === 1'b0); n++)
            @(negedge mclk);
        bound(n);
        @(negedge mclk);
        host_req = '0;
        get_tel();
        chk("host tel", {r.addr, r.exp}, {tel.addr, tel.cmd});
        chk("host reply", {1'b1, r.addr, 2'h1, 12'h0, r.addr}, rep);
    endtask
    task automatic pin(bit two, bit lvl, logic [2:0] exp);
        if (two) manual_input_two = lvl;
        else manual_input_one = lvl;
        get_tel();
        chk("manual cmd", exp, tel.cmd);
        chk("manual dest", {1'b1, mbo_pkg::BCAST_ADDR}, {tel.broadcast, tel.addr});
    endtask
    initial begin
        repeat (5) @(negedge mclk);
        chk("lock in reset", 0, manual_lock);
        reset = 0;
        $display("test reset done");
        foreach (rows[i]) begin
            slow = i[0];
            send(rows[i], 0);
            seen[rows[i].addr] = 1'b1;
        end
        repeat (2) @(negedge mclk);
        chk("drive seen", seen, drive_seen);
        $display("test host rows done");
        pin(0, 1, 3'h1);
        pin(0, 0, 3'h0);
        pin(1, 1, 3'h2);
        quiet();
        pin(1, 0, 3'h0);
        chk("lock", 1, manual_lock);
        send(rows[1], 1);
        host_command_reenable = 0;
        $display("test manual and lock done");
        map_in = '{3'h4, 3'h5, 3'h1, 3'h0};
        map_load = 1;
        @(negedge mclk);
        map_load = 0;
        pin(0, 1, 3'h4);
        manual_input_one = 0;
        quiet();
        pin(1, 1, 3'h1);
        $display("test map done");
        // pins low while reset holds, so no false edge follows the release
        manual_input_two = 0;
        reset = 1;
        repeat (3) @(negedge mclk);
        chk("lock after reset", 0, manual_lock);
        chk("ready in reset", 0, host_ready);
        chk("seen after reset", 0, drive_seen);
        reset = 0;
        pin(0, 1, 3'h1);
        quiet();
        $display("test mid-run reset done");
        complete_run();
    end
endmodule
